// >>> rtl/uvp_prog_ctrl.sv
// Purpose: programming sequencer for a 64k x 16 uv eprom, from the host side
// Assumes: image words come from a user port addressed by the sequencer
// Notes: supply levels are requested by outputs; the board switches them
`timescale 1ns/1ps
`include "uvp_cfg.svh"
module uvp_prog_ctrl #(
  parameter int ADDR_W = 16,
  parameter int FAST_PW_CYC = `UVP_FAST_PW_CYC,
  parameter int INT_PW_CYC = `UVP_INT_PW_CYC,
  parameter int OVP_PW_CYC = `UVP_OVP_PW_CYC,
  parameter int VPP_SETTLE_CYC = `UVP_SETUP_CYC,
  parameter int FAST_MAX = `UVP_FAST_MAX_PULSES,
  parameter int INT_MAX = `UVP_INT_MAX_PULSES
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic fast_i,
  input wire logic [ADDR_W-1:0] last_addr_i,
  output logic [ADDR_W-1:0] img_addr_o,
  input wire logic [15:0] img_data_i,
  output logic busy_o,
  output logic done_o,
  output logic fail_o,
  output logic [ADDR_W-1:0] fail_addr_o,
  output logic vpp_high_o,
  output logic vcc_high_o,
  output logic select_n_o,
  output logic gate_n_o,
  output logic strobe_n_o,
  output logic [15:0] addr_o,
  output logic [15:0] data_o,
  output logic data_oe_o,
  input wire logic [15:0] data_i
);
  typedef enum logic [3:0] {
    S_IDLE, S_VPP_UP, S_PULSE, S_VERIFY, S_NEXT, S_OVP,
    S_VPP_DOWN, S_FINAL, S_DONE
  } uvp_seq_t;
  uvp_seq_t st_ff; // sequencer state
  uvp_pkg::uvp_alg_t alg_ff; // algorithm chosen at start
  logic [ADDR_W-1:0] addr_ff; // current address
  logic [ADDR_W-1:0] last_ff; // last address latched at start
  logic [7:0] npulse_ff; // pulses given at current address
  logic [31:0] settle_ff; // supply settle counter
  logic issued_ff; // a pin cycle is outstanding
  logic fail_ff; // failure flag
  logic done_ff; // completion flag
  logic [ADDR_W-1:0] fail_addr_ff; // first failing address
  logic match; // exact verify compare
  logic at_limit; // pulse budget spent
  uvp_cyc_if cyc ();
  uvp_pin_drv u_drv (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .cyc(cyc),
    .select_n_o(select_n_o),
    .gate_n_o(gate_n_o),
    .strobe_n_o(strobe_n_o),
    .addr_o(addr_o),
    .data_o(data_o),
    .data_oe_o(data_oe_o),
    .data_i(data_i)
  );
  // exact word compare; a zero cannot return to one, so no rewrite helps
  function automatic logic word_ok(input logic [15:0] got, input logic [15:0] want);
    word_ok = (got == want);
  endfunction
  assign match = word_ok(cyc.rdata, img_data_i); // RULE20 RULE2
  assign at_limit = alg_ff == uvp_pkg::UVP_ALG_FAST ?
                    (npulse_ff >= 8'(FAST_MAX)) : (npulse_ff >= 8'(INT_MAX)); // RULE11 RULE6
  assign img_addr_o = addr_ff;
  // request one pin cycle per state visit; S_OVP and S_FINAL request one per address
  always_comb begin
    cyc.start = 1'b0;
    cyc.op = uvp_pkg::UVP_OP_IDLE;
    cyc.pulse_cyc = 32'(FAST_PW_CYC);
    cyc.addr = 16'(addr_ff);
    cyc.wdata = img_data_i; // RULE5
    if (!issued_ff) begin
      unique case (st_ff)
        S_PULSE: begin
          cyc.start = 1'b1;
          cyc.op = uvp_pkg::UVP_OP_PROG;
          cyc.pulse_cyc = (alg_ff == uvp_pkg::UVP_ALG_FAST) ?
                          32'(FAST_PW_CYC) : 32'(INT_PW_CYC); // RULE10
        end
        S_OVP: begin
          cyc.start = 1'b1;
          cyc.op = uvp_pkg::UVP_OP_PROG;
          cyc.pulse_cyc = 32'(OVP_PW_CYC); // RULE8
        end
        S_VERIFY: begin
          cyc.start = 1'b1;
          cyc.op = uvp_pkg::UVP_OP_VERIFY; // RULE15
        end
        S_FINAL: begin
          // no read until the supplies have settled at nominal
          cyc.start = (settle_ff == 32'h0); // RULE9 RULE12
          cyc.op = uvp_pkg::UVP_OP_READ;
        end
        default: cyc.start = 1'b0;
      endcase
    end
  end
  // outstanding flag: set by request, cleared by done
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      issued_ff <= 1'b0;
    end else if (cyc.done) begin
      issued_ff <= 1'b0;
    end else if (cyc.start) begin
      issued_ff <= 1'b1;
    end
  end
  // main algorithm sequencer
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      st_ff <= S_IDLE;
      alg_ff <= uvp_pkg::UVP_ALG_INTERACTIVE;
      addr_ff <= '0;
      last_ff <= '0;
      npulse_ff <= 8'h0;
      settle_ff <= 32'h0;
    end else begin
      unique case (st_ff)
        S_IDLE: begin
          if (start_i) begin
            alg_ff <= fast_i ? uvp_pkg::UVP_ALG_FAST : uvp_pkg::UVP_ALG_INTERACTIVE;
            last_ff <= last_addr_i;
            addr_ff <= '0;
            npulse_ff <= 8'h0;
            settle_ff <= 32'(VPP_SETTLE_CYC);
            st_ff <= S_VPP_UP;
          end
        end
        S_VPP_UP: begin
          // supply rises with gate and strobe/select idle high  RULE3 RULE4
          if (settle_ff == 32'h0) st_ff <= S_PULSE;
          else settle_ff <= settle_ff - 32'h1;
        end
        S_PULSE: begin
          if (cyc.done) begin
            npulse_ff <= npulse_ff + 8'h1;
            st_ff <= S_VERIFY; // RULE6
          end
        end
        S_VERIFY: begin
          if (cyc.done) begin
            if (match) begin
              st_ff <= S_NEXT;
            end else if (at_limit) begin
              st_ff <= S_VPP_DOWN; // RULE20 give up
            end else begin
              st_ff <= S_PULSE; // RULE11
            end
          end
        end
        S_NEXT: begin
          npulse_ff <= 8'h0;
          if (addr_ff == last_ff) begin
            addr_ff <= '0;
            st_ff <= (alg_ff == uvp_pkg::UVP_ALG_INTERACTIVE) ? S_OVP : S_VPP_DOWN; // RULE8
          end else begin
            addr_ff <= addr_ff + 1'b1; // RULE7
            st_ff <= S_PULSE;
          end
        end
        S_OVP: begin
          if (cyc.done) begin
            if (addr_ff == last_ff) begin
              st_ff <= S_VPP_DOWN;
            end else begin
              addr_ff <= addr_ff + 1'b1; // RULE8
            end
          end
        end
        S_VPP_DOWN: begin
          addr_ff <= '0;
          settle_ff <= 32'(VPP_SETTLE_CYC);
          st_ff <= fail_ff ? S_DONE : S_FINAL;
        end
        S_FINAL: begin
          // words read back at nominal supplies, stopping at the first mismatch  RULE9 RULE12
          if (settle_ff != 32'h0) begin
            settle_ff <= settle_ff - 32'h1;
          end else if (cyc.done) begin
            if (!match || addr_ff == last_ff) st_ff <= S_DONE;
            else addr_ff <= addr_ff + 1'b1;
          end
        end
        S_DONE: st_ff <= S_IDLE;
        default: st_ff <= S_IDLE;
      endcase
    end
  end
  // result flags: fail sticks until next start
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      fail_ff <= 1'b0;
      fail_addr_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= (st_ff == S_DONE);
      if (st_ff == S_IDLE && start_i) begin
        fail_ff <= 1'b0;
      end else if ((st_ff == S_VERIFY && cyc.done && !match && at_limit)
                   || (st_ff == S_FINAL && settle_ff == 32'h0 && cyc.done && !match)) begin
        fail_ff <= 1'b1; // RULE20
        fail_addr_ff <= addr_ff;
      end
    end
  end
  // supply requests: programming levels only during programming phases
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      vpp_high_o <= 1'b0;
      vcc_high_o <= 1'b0;
    end else begin
      vpp_high_o <= st_ff inside {S_VPP_UP, S_PULSE, S_VERIFY, S_NEXT, S_OVP};
      vcc_high_o <= st_ff inside {S_VPP_UP, S_PULSE, S_VERIFY, S_NEXT, S_OVP};
    end
  end
  assign busy_o = (st_ff != S_IDLE);
  assign done_o = done_ff;
  assign fail_o = fail_ff;
  assign fail_addr_o = fail_addr_ff;
  // strobe low never longer than the longest pulse in play
  logic [31:0] low_cnt_ff; // assertion helper
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) low_cnt_ff <= 32'h0;
    else low_cnt_ff <= strobe_n_o ? 32'h0 : low_cnt_ff + 32'h1;
  end
  property p_pulse_len;
    @(posedge sys_clk_i) disable iff (!reset_n_i) low_cnt_ff <= 32'(OVP_PW_CYC) + 32'h1;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("strobe low too long"); // RULE10
  property p_strobe_data;
    @(posedge sys_clk_i) disable iff (!reset_n_i) !strobe_n_o |-> data_oe_o && !select_n_o;
  endproperty
  a_strobe_data: assert property (p_strobe_data) else $error("strobe without data"); // RULE5
  property p_no_contention;
    @(posedge sys_clk_i) disable iff (!reset_n_i) data_oe_o |-> gate_n_o;
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("drive with gate low"); // RULE15
  property p_strobe_vpp;
    @(posedge sys_clk_i) disable iff (!reset_n_i) !strobe_n_o |-> vpp_high_o;
  endproperty
  a_strobe_vpp: assert property (p_strobe_vpp) else $error("pulse without vpp"); // RULE3
  property p_count;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      alg_ff == uvp_pkg::UVP_ALG_FAST |-> npulse_ff <= 8'(FAST_MAX);
  endproperty
  a_count: assert property (p_count) else $error("pulse budget exceeded"); // RULE11
  property p_fail_keeps;
    @(posedge sys_clk_i) disable iff (!reset_n_i) fail_ff && !start_i |=> fail_ff;
  endproperty
  a_fail_keeps: assert property (p_fail_keeps) else $error("fail flag lost"); // RULE20
  property p_final_nominal;
    @(posedge sys_clk_i) disable iff (!reset_n_i) st_ff == S_FINAL |=> !vpp_high_o;
  endproperty
  a_final_nominal: assert property (p_final_nominal) else $error("final read at vpp"); // RULE12
  property p_idle_pins;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      st_ff == S_IDLE && $past(st_ff) == S_IDLE |-> select_n_o && strobe_n_o;
  endproperty
  a_idle_pins: assert property (p_idle_pins) else $error("pins active while idle"); // RULE14
endmodule

// >>> rtl/uvp_cfg.svh
// Purpose: constants for the eprom programming controller
// Assumes: 250 mhz system clock, 4 ns period
// Notes: timing counts derive from printed figures
// Overview of operation
// RULE1: erased cells read as all ones
// RULE2: programming only clears ones to zeros
// RULE3: word part: supply up, gate high, strobe low
// RULE4: selectable part: supply up, gate high, select low
// RULE5: present full sixteen bit word when programming
// RULE6: verify after each pulse, repeat until limit
// RULE7: loop over every address in turn
// RULE8: interactive mode adds one overprogram pulse everywhere
// RULE9: interactive mode ends with full verify at nominal
// RULE10: fast pulse is 100 us after stable lines
// RULE11: fast mode allows at most 25 pulses
// RULE12: fast mode ends verifying all at nominal
// RULE13: select and gate driven per part
// RULE14: select high inhibits programming of a part
// RULE15: verify reads with gate and select low
// RULE16: top data pin is low address in byte mode; the controller has no byte mode and uses all sixteen data pins as data, driving them only while programming
// RULE17: byte mode: low address picks high or low byte; the controller programs and reads whole sixteen bit words only
// RULE18: select inactive floats all outputs
// RULE19: data only with select and gate low
// RULE20: exact compare, count pulses, flag exhaustion
`ifndef UVP_CFG_SVH
`define UVP_CFG_SVH
`define UVP_CLK_MHZ 250
`define UVP_FAST_PW_US 100
`define UVP_FAST_PW_CYC ((`UVP_FAST_PW_US * `UVP_CLK_MHZ))
`define UVP_INT_PW_US 1000
`define UVP_INT_PW_CYC ((`UVP_INT_PW_US * `UVP_CLK_MHZ))
`define UVP_OVP_PW_US 2000
`define UVP_OVP_PW_CYC ((`UVP_OVP_PW_US * `UVP_CLK_MHZ))
`define UVP_SETUP_US 2
`define UVP_SETUP_CYC ((`UVP_SETUP_US * `UVP_CLK_MHZ))
`define UVP_ACC_NS 160
`define UVP_ACC_CYC ((`UVP_ACC_NS + 3) / 4)
`define UVP_FAST_MAX_PULSES 25
`define UVP_INT_MAX_PULSES 25
`define UVP_ERASED_WORD 16'hffff
`endif

// >>> rtl/uvp_pkg.sv
// Purpose: types shared by the eprom programming controller
// Assumes: nothing beyond the cfg header
// Notes: no constants here, only types
package uvp_pkg;
  // pin cycle operations
  typedef enum logic [2:0] {
    UVP_OP_IDLE,
    UVP_OP_READ,
    UVP_OP_PROG,
    UVP_OP_VERIFY
  } uvp_op_t;
  // algorithm choice
  typedef enum logic {
    UVP_ALG_INTERACTIVE,
    UVP_ALG_FAST
  } uvp_alg_t;
endpackage

// >>> rtl/uvp_cyc_if.sv
// Purpose: internal carrier between sequencer and pin driver
// Assumes: one clock domain
// Notes: sequencer requests one pin cycle, driver answers done
`timescale 1ns/1ps
interface uvp_cyc_if;
  uvp_pkg::uvp_op_t op; // requested pin cycle
  logic start; // one-cycle request pulse
  logic [31:0] pulse_cyc; // program pulse length in cycles
  logic [15:0] addr; // word address
  logic [15:0] wdata; // word to program
  logic [15:0] rdata; // word read back
  logic done; // one-cycle completion
  modport seq(output op, start, pulse_cyc, addr, wdata, input rdata, done);
  modport drv(input op, start, pulse_cyc, addr, wdata, output rdata, done);
endinterface

// >>> rtl/uvp_timer.sv
// Purpose: down counter used for pulse and setup timing
// Assumes: load and tick on the same clock
// Notes: expired is high while count is zero
`timescale 1ns/1ps
module uvp_timer #(
  parameter int W = 32
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  output logic expired_o
);
  logic [W-1:0] cnt_ff; // remaining cycles
  // load wins over counting down
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      cnt_ff <= '0;
    end else if (load_i) begin
      cnt_ff <= value_i;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end
  assign expired_o = (cnt_ff == '0);
endmodule

// >>> rtl/uvp_pin_drv.sv
// Purpose: drives one program, verify or read cycle on the part pins
// Assumes: part is held in programming mode by the sequencer for program/verify
// Notes: data pins float except while programming
`timescale 1ns/1ps
`include "uvp_cfg.svh"
module uvp_pin_drv (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  uvp_cyc_if.drv cyc,
  output logic select_n_o,
  output logic gate_n_o,
  output logic strobe_n_o,
  output logic [15:0] addr_o,
  output logic [15:0] data_o,
  output logic data_oe_o,
  input wire logic [15:0] data_i
);
  typedef enum logic [1:0] {PD_IDLE, PD_SETUP, PD_ACTIVE, PD_HOLD} uvp_pd_t;
  uvp_pd_t st_ff; // pin phase
  uvp_pkg::uvp_op_t op_ff; // op in flight
  logic [31:0] pw_ff; // pulse length held here, the request lines do not stay put
  logic tload; // timer load
  logic [31:0] tval; // timer value
  logic texp; // timer expired
  uvp_timer #(.W(32)) u_tmr (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .load_i(tload),
    .value_i(tval),
    .expired_o(texp)
  );
  // timer loads on entering each timed phase
  always_comb begin
    tload = 1'b0;
    tval = 32'h0;
    if (st_ff == PD_IDLE && cyc.start) begin
      tload = 1'b1;
      tval = 32'(`UVP_SETUP_CYC);
    end else if (st_ff == PD_SETUP && texp) begin
      tload = 1'b1;
      // one less: the strobe already falls on this loading edge
      tval = (op_ff == uvp_pkg::UVP_OP_PROG) ? pw_ff - 32'h1 : 32'(`UVP_ACC_CYC);
    end else if (st_ff == PD_ACTIVE && texp) begin
      tload = 1'b1;
      tval = 32'(`UVP_SETUP_CYC);
    end
  end
  // phase sequencing: lines settle before strobe, hold after
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      st_ff <= PD_IDLE;
      op_ff <= uvp_pkg::UVP_OP_IDLE;
      pw_ff <= 32'h0;
    end else begin
      unique case (st_ff)
        PD_IDLE: begin
          if (cyc.start) begin
            st_ff <= PD_SETUP;
            op_ff <= cyc.op;
            pw_ff <= cyc.pulse_cyc; // RULE10
          end
        end
        PD_SETUP: if (texp) st_ff <= PD_ACTIVE;
        PD_ACTIVE: if (texp) st_ff <= PD_HOLD;
        PD_HOLD: if (texp) st_ff <= PD_IDLE;
      endcase
    end
  end
  // pins: select low only for own cycle, else part inhibited/standby
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      select_n_o <= 1'b1;
      gate_n_o <= 1'b1;
      strobe_n_o <= 1'b1;
      addr_o <= 16'h0;
      data_o <= 16'h0;
      data_oe_o <= 1'b0;
    end else begin
      if (st_ff == PD_IDLE && cyc.start) begin
        addr_o <= cyc.addr; // address stable before strobe  RULE10
        data_o <= cyc.wdata; // full word in parallel  RULE5
        data_oe_o <= (cyc.op == uvp_pkg::UVP_OP_PROG);
        select_n_o <= 1'b0; // RULE13
      end
      strobe_n_o <= !(st_ff == PD_SETUP && texp && op_ff == uvp_pkg::UVP_OP_PROG)
                    && !(st_ff == PD_ACTIVE && !texp && op_ff == uvp_pkg::UVP_OP_PROG); // RULE10
      gate_n_o <= !(op_ff != uvp_pkg::UVP_OP_PROG && st_ff != PD_IDLE
                    && !(st_ff == PD_HOLD)); // RULE15 RULE19
      if (st_ff == PD_HOLD && texp) begin
        select_n_o <= 1'b1; // RULE14 RULE18
        data_oe_o <= 1'b0;
      end
    end
  end
  // capture read word at end of access window
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      cyc.rdata <= `UVP_ERASED_WORD; // RULE1
    end else if (st_ff == PD_ACTIVE && texp && op_ff != uvp_pkg::UVP_OP_PROG) begin
      cyc.rdata <= data_i; // RULE15
    end
  end
  assign cyc.done = (st_ff == PD_HOLD) && texp;
endmodule

// >>> bench/uvp_eprom_model.sv
// Purpose: behavioural word-wide uv eprom facing the programming sequencer
// Assumes: pins are sampled on the bench clock; word mode only
// Notes: a released bus shows a pattern that changes every cycle
`timescale 1ns/1ps
module uvp_eprom_model #(
  parameter int DEPTH = 65536,
  parameter int ACC_CYC = 30
) (
  input wire logic clk_i,
  input wire logic erase_i,
  input wire logic [15:0] weak_addr_i,
  input wire logic [7:0] weak_need_i,
  input wire logic [15:0] weak_zero_i,
  input wire logic vpp_high_i,
  input wire logic select_n_i,
  input wire logic gate_n_i,
  input wire logic strobe_n_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] data_i,
  input wire logic data_oe_i,
  output logic [15:0] data_o
);
  logic [15:0] mem [DEPTH]; // cell array
  logic [7:0] hits_ff [DEPTH]; // pulses taken per word
  logic [15:0] last_ff = 16'h0000; // last bus level, inverted once released
  logic [7:0] acc_ff = 8'h00; // cycles since both enables went low
  logic strobe_q_ff = 1'b1; // strobe one cycle ago, for edge finding
  logic rd; // output path open
  assign rd = !select_n_i && !gate_n_i;
  // stored word only after the access time, so a hasty sample sees junk
  always_comb begin
    if (rd && acc_ff >= 8'(ACC_CYC)) data_o = mem[addr_i];
    else if (data_oe_i) data_o = data_i;
    else data_o = ~last_ff;
  end
  // erase, program pulses and access timing
  always @(posedge clk_i) begin
    last_ff <= data_o;
    strobe_q_ff <= strobe_n_i;
    acc_ff <= rd ? ((acc_ff == 8'hff) ? acc_ff : acc_ff + 8'h01) : 8'h00;
    if (erase_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= 16'hffff;
        hits_ff[i] <= 8'h00;
      end
      // a weak word may also hold zeros that no pulse can lift
      mem[weak_addr_i] <= ~weak_zero_i;
    end else if (vpp_high_i && !select_n_i && gate_n_i && !strobe_n_i && strobe_q_ff) begin
      hits_ff[addr_i] <= hits_ff[addr_i] + 8'h01;
      if (addr_i != weak_addr_i || hits_ff[addr_i] + 8'h01 >= weak_need_i)
        mem[addr_i] <= mem[addr_i] & data_i;
    end
  end
endmodule

// >>> bench/test_uv_eprom_program_read_port.sv
// Purpose: self-checking bench for the eprom programming sequencer
// Assumes: word mode, sixteen word image, shortened pulse parameters
// Notes: image words come from a fixed-seed lfsr
`timescale 1ns/1ps
`define CHK(a, b, m) begin samples_checked++; if ((a) !== (b)) bad_note(m); end
module test_uv_eprom_program_read_port;
  localparam int FPW = 20; // fast pulse, cycles
  localparam int IPW = 40; // interactive pulse
  localparam int OPW = 80; // overprogram pulse
  localparam int PMAX = 25; // pulse limit per word
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic start = 1'b0;
  logic fast = 1'b0;
  logic erase = 1'b1;
  logic [15:0] last_addr = 16'h0000;
  logic [15:0] weak_addr = 16'h0000;
  logic [15:0] weak_zero = 16'h0000;
  logic [7:0] weak_need = 8'h01;
  logic [15:0] img_addr, img_data, fail_addr, addr_o, data_o, part_data, pdata, pa;
  logic busy, done, fail, vpp_high, vcc_high, select_n, gate_n, strobe_n, data_oe;
  logic [15:0] img [16]; // image per address
  logic nom [16]; // word read back at nominal supplies
  int npls [16]; // program pulses per word
  int novp [16]; // overprogram pulses per word
  int pw = 0;
  int ndone = 0;
  int fail_count = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'h89df;
  assign img_data = img[img_addr[3:0]];
  always #2 sys_clk = ~sys_clk;
  uvp_prog_ctrl #(.FAST_PW_CYC(FPW), .INT_PW_CYC(IPW), .OVP_PW_CYC(OPW),
    .VPP_SETTLE_CYC(10), .FAST_MAX(PMAX), .INT_MAX(PMAX)) DUT (
    .sys_clk_i(sys_clk), .reset_n_i(reset_n), .start_i(start), .fast_i(fast),
    .last_addr_i(last_addr), .img_addr_o(img_addr), .img_data_i(img_data),
    .busy_o(busy), .done_o(done), .fail_o(fail), .fail_addr_o(fail_addr),
    .vpp_high_o(vpp_high), .vcc_high_o(vcc_high), .select_n_o(select_n),
    .gate_n_o(gate_n), .strobe_n_o(strobe_n), .addr_o(addr_o), .data_o(data_o),
    .data_oe_o(data_oe), .data_i(part_data));
  uvp_eprom_model #(.DEPTH(16)) u_part (
    .clk_i(sys_clk), .erase_i(erase), .weak_addr_i(weak_addr), .weak_need_i(weak_need),
    .weak_zero_i(weak_zero), .vpp_high_i(vpp_high), .select_n_i(select_n),
    .gate_n_i(gate_n), .strobe_n_i(strobe_n), .addr_i(addr_o), .data_i(data_o),
    .data_oe_i(data_oe), .data_o(part_data));
  task automatic bad_note(input string m);
    fail_count++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic close_out();
    if (fail_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // pulses a word should take: one, the weak word's need, or the limit
  function automatic int exp_pls(input int a, input int wa, input int need, input logic bad);
    return (a != wa) ? 1 : (bad ? PMAX : need);
  endfunction
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask
  // pin watcher: pulse shape, bus ownership and nominal reads
  always @(posedge sys_clk) begin
    if (reset_n && busy) begin
      `CHK(data_oe && !select_n && !gate_n, 1'b0, "bus fight")
      if (!select_n && !gate_n && !vpp_high && !vcc_high) nom[addr_o[3:0]] = 1'b1;
      if (!strobe_n) begin
        `CHK({gate_n, select_n, vpp_high, vcc_high, data_oe}, 5'h17, "pulse pins")
        if (pw == 0) begin
          pdata = data_o;
          pa = addr_o;
        end
        `CHK({data_o, addr_o}, {pdata, pa}, "lines moved")
        pw++;
      end else if (pw != 0) begin
        `CHK(pw == (fast ? FPW : IPW) || (!fast && pw == OPW), 1'b1, "pulse width")
        if (pw == OPW) novp[pa[3:0]]++;
        else npls[pa[3:0]]++;
        pw = 0;
      end
    end
    if (done === 1'b1) ndone++;
  end
  // one whole programming run with a weak or stuck word at wa
  task automatic run(input logic f, input int last, input int wa, input int need,
    input logic [15:0] zero, input logic bad);
    int n;
    for (int a = 0; a < 16; a++) begin
      seed = lfsr(seed);
      img[a] = seed[15:0] | ((a == wa) ? zero : 16'h0000);
      npls[a] = 0;
      novp[a] = 0;
      nom[a] = 1'b0;
    end
    weak_addr = 16'(wa);
    weak_need = 8'(need);
    weak_zero = zero;
    erase = 1'b1;
    step();
    erase = 1'b0;
    fast = f;
    last_addr = 16'(last);
    ndone = 0;
    start = 1'b1;
    // held well past acceptance: repeats while busy must be ignored
    for (n = 0; n < 8; n++) step();
    start = 1'b0;
    for (n = 0; n < 60000 && done !== 1'b1; n++) step();
    if (n == 60000) begin
      bad_note("no done");
      close_out();
    end
    `CHK(fail, bad, "fail flag")
    if (bad) `CHK(fail_addr, 16'(wa), "fail address")
    if (bad) `CHK(u_part.mem[wa] & zero, 16'h0000, "zero lifted")
    step();
    `CHK(busy, 1'b0, "busy after done")
    `CHK(ndone, 1, "done count")
    for (int a = 0; a <= last + 1; a++) begin
      `CHK(npls[a], (a > last) ? 0 : exp_pls(a, wa, need, bad), "pulses")
      if (!bad && a <= last) begin
        `CHK(novp[a], f ? 0 : 1, "overprogram")
        `CHK(nom[a], 1'b1, "nominal verify")
        `CHK(u_part.mem[a], img[a], "cell contents")
      end
    end
  endtask
  // reset, erased check, then fast, interactive, random and stuck runs
  initial begin
    step();
    step();
    reset_n = 1'b1;
    `CHK({select_n, gate_n, strobe_n, data_oe, vpp_high, vcc_high, busy, done, fail},
      9'h1c0, "reset state")
    `CHK(u_part.mem[5], 16'hffff, "erased word")
    run(1'b1, 3, 2, 3, 16'h0000, 1'b0);
    run(1'b0, 2, 0, 2, 16'h0000, 1'b0);
    seed = lfsr(seed);
    run(1'b1, int'(seed[0]), 15, 1, 16'h0000, 1'b0);
    run(1'b1, 1, 1, 1, 16'h0001, 1'b1);
    close_out();
  end
endmodule
